// ---- pts_pkg.sv ----
// Purpose: Shared constants and decode for the turn-on/turn-off sequencer.
// Assumes: Master clock from the power manager runs at PTS_MCLK_PER_US cycles per microsecond.
// Notes:   Reference values are in units of one 10 mV step.
//
// Summary of operation
// - With falling slew on, turn-off delay runs from command until output reaches zero.
// - Slewed turn-off waits programmed delay minus output over falling rate, then ramps.
// - Without falling slew, both switches go off when the turn-off delay expires.
// - Turn-off delay is six bits, one millisecond per count, resetting to 11.
// - Upper two bits of the turn-off delay register read as zero.
// - Rising slew code 0..6 selects 0.05 to 2.0 V/ms; code 7 reserved.
// - One bit enables controlled falling slew; it resets to enabled.
// - Three low bits select falling slew rate, same steps as rising.
// - Reference moves in 10 mV steps; dwell per step sets the slew rate.
// - Step dwell comes from dividing the manager's master clock.
// - Into a pre-biased output, switches stay off until reference exceeds the output or the ramp reaches its target.
// - Falling slew choice is independent of rising slew choice.
// - Longest turn-off delay is shorter than longest turn-on delay.
// - Turn-on delay runs from turn-on command until the ramp starts.
`default_nettype none

package pts_pkg;

	// Register map and reset values.
	localparam logic [7:0] PTS_ADDR_RAMP    = 8'h03;
	localparam logic [7:0] PTS_ADDR_OFF_DLY = 8'h06;
	localparam logic [6:0] PTS_RAMP_RESET   = 7'h1C;
	localparam logic [5:0] PTS_OFF_RESET    = 6'h0B;

	// Field positions inside the ramp rate register.
	localparam int PTS_RISE_LSB = 4;
	localparam int PTS_SLEW_BIT = 3;
	localparam int PTS_FALL_LSB = 0;

	// Time base counts.
	localparam logic [7:0] PTS_MCLK_PER_US = 8'h01;
	localparam logic [9:0] PTS_US_PER_MS   = 10'h3E8;

	// Sequencer states, one-hot.
	typedef enum logic [5:0] {
		ST_OFF       = 6'h01,
		ST_ON_DLY    = 6'h02,
		ST_RAMP_UP   = 6'h04,
		ST_ON        = 6'h08,
		ST_OFF_DLY   = 6'h10,
		ST_RAMP_DOWN = 6'h20
	} pts_state_t;

	// Microseconds per 10 mV step for a slew code; reserved code takes the slowest rate.
	function automatic logic [7:0] pts_step_us(input logic [2:0] code);
		case (code)
			3'h0: pts_step_us = 8'hC8;
			3'h1: pts_step_us = 8'h64;
			3'h2: pts_step_us = 8'h32;
			3'h3: pts_step_us = 8'h28;
			3'h4: pts_step_us = 8'h14;
			3'h5: pts_step_us = 8'h0A;
			3'h6: pts_step_us = 8'h05;
			default: pts_step_us = 8'hC8;
		endcase
	endfunction

endpackage

`default_nettype wire

// ---- pts_tick_if.sv ----
// Purpose: Carries time base ticks and step length between sequencer and time base.
// Assumes: Both ends share sys_clk_in.
// Notes:   Ticks are one-cycle pulses.
`default_nettype none

interface pts_tick_if;
	logic       us_tick;
	logic       ms_tick;
	logic       step_tick;
	logic       step_restart;
	logic [7:0] step_len_us;

	modport base (output us_tick, output ms_tick, output step_tick, input step_restart, input step_len_us);
	modport user (input us_tick, input ms_tick, input step_tick, output step_restart, output step_len_us);
endinterface

`default_nettype wire

// ---- pts_timebase.sv ----
// Purpose: Divides the manager's master clock into microsecond, millisecond and step ticks.
// Assumes: master_clk_in is slower than half of sys_clk_in.
// Notes:   Master clock is asynchronous and passes two flip-flops first.
`default_nettype none

module pts_timebase
	import pts_pkg::*;
(
	// Clock and reset.
	input  wire logic sys_clk_in,
	input  wire logic reset_in,
	// Master clock pin.
	input  wire logic master_clk_in,
	// Tick carrier.
	pts_tick_if.base  tick
);

	logic       sync1, sync2, sync3;
	logic [7:0] mclk_cnt, next_mclk_cnt;
	logic [9:0] us_cnt, next_us_cnt;
	logic [7:0] step_cnt, next_step_cnt;
	logic       next_us, next_ms, next_step;
	logic       mclk_edge;

	assign mclk_edge = sync2 & ~sync3;

	// Divider chain; all ticks derive from the master clock so ramps stay in lockstep.
	always_comb begin
		next_mclk_cnt = mclk_cnt;
		next_us_cnt   = us_cnt;
		next_step_cnt = step_cnt;
		next_us       = 1'b0;
		next_ms       = 1'b0;
		next_step     = 1'b0;
		if (mclk_edge) begin
			if (mclk_cnt >= PTS_MCLK_PER_US - 8'h01) begin
				next_mclk_cnt = 8'h00;
				next_us       = 1'b1;
			end else begin
				next_mclk_cnt = mclk_cnt + 8'h01;
			end
		end
		if (tick.us_tick) begin
			if (us_cnt >= PTS_US_PER_MS - 10'h001) begin
				next_us_cnt = 10'h000;
				next_ms     = 1'b1;
			end else begin
				next_us_cnt = us_cnt + 10'h001;
			end
		end
		if (tick.step_restart) begin
			next_step_cnt = 8'h00;
		end else if (tick.us_tick) begin
			if (step_cnt >= tick.step_len_us - 8'h01) begin
				next_step_cnt = 8'h00;
				next_step     = 1'b1;
			end else begin
				next_step_cnt = step_cnt + 8'h01;
			end
		end
	end

	// Registers of the divider chain and the synchroniser.
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			sync1          <= 1'b0;
			sync2          <= 1'b0;
			sync3          <= 1'b0;
			mclk_cnt       <= 8'h00;
			us_cnt         <= 10'h000;
			step_cnt       <= 8'h00;
			tick.us_tick   <= 1'b0;
			tick.ms_tick   <= 1'b0;
			tick.step_tick <= 1'b0;
		end else begin
			sync1          <= master_clk_in;
			sync2          <= sync1;
			sync3          <= sync2;
			mclk_cnt       <= next_mclk_cnt;
			us_cnt         <= next_us_cnt;
			step_cnt       <= next_step_cnt;
			tick.us_tick   <= next_us;
			tick.ms_tick   <= next_ms;
			tick.step_tick <= next_step;
		end
	end

	// A step tick is decoded from a microsecond tick, so it only ever follows one by a cycle.
	property p_step_on_us;
		@(posedge sys_clk_in) disable iff (reset_in) tick.step_tick |-> $past(tick.us_tick);
	endproperty
	a_step_on_us: assert property (p_step_on_us) else $error("step tick without us tick");

	// A millisecond tick is decoded from a microsecond tick, so it only ever follows one by a cycle.
	property p_ms_on_us;
		@(posedge sys_clk_in) disable iff (reset_in) tick.ms_tick |-> $past(tick.us_tick);
	endproperty
	a_ms_on_us: assert property (p_ms_on_us) else $error("ms tick without us tick");

endmodule

`default_nettype wire

// ---- pts_sequencer.sv ----
// Purpose: Turn-on/turn-off sequencer with delay counting and slewed reference ramps.
// Assumes: Register and command ports come from the single-wire bus decoder on sys_clk_in.
// Notes:   Voltages are in 10 mV steps; slewed turn-off with a too short delay ramps at once.
`default_nettype none

module pts_sequencer
	import pts_pkg::*;
(
	// Clock and reset.
	input  wire logic       sys_clk_in,
	input  wire logic       reset_in,
	// Master clock pin from the power manager.
	input  wire logic       master_clk_in,
	// Register access from the bus decoder.
	input  wire logic [7:0] reg_addr_in,
	input  wire logic       reg_wr_in,
	input  wire logic [7:0] reg_wdata_in,
	output logic      [7:0] reg_rdata_out,
	// Commands and settings.
	input  wire logic       turn_on_cmd_in,
	input  wire logic       turn_off_cmd_in,
	input  wire logic [7:0] turn_on_delay_ms_in,
	input  wire logic [9:0] vout_target_in,
	input  wire logic [9:0] vout_sense_in,
	// Power stage control.
	output logic      [9:0] vref_out,
	output logic            switch_enable_out,
	output logic            ramp_done_out
);

	pts_tick_if tick ();

	pts_state_t  state, next_state;
	logic [6:0]  ramp_rate_register, next_ramp_rate;
	logic [5:0]  turn_off_delay_ms, next_off_dly;
	logic [7:0]  next_rdata;
	logic [7:0]  on_cnt, next_on_cnt;
	logic [15:0] rem_us, next_rem_us;
	logic        hold, next_hold;
	logic [9:0]  next_vref;
	logic        next_switch, next_done, restart;
	logic        fall_slew_enable;
	logic [7:0]  rise_us, fall_us;
	logic [17:0] need_us;

	pts_timebase u_timebase (
		.sys_clk_in    (sys_clk_in),
		.reset_in      (reset_in),
		.master_clk_in (master_clk_in),
		.tick          (tick.base)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Register file.

	// Write decode and registered read data; unmapped addresses read zero.
	always_comb begin
		next_ramp_rate = ramp_rate_register;
		next_off_dly   = turn_off_delay_ms;
		if (reg_wr_in && reg_addr_in == PTS_ADDR_RAMP) begin
			next_ramp_rate = reg_wdata_in[6:0];
		end
		if (reg_wr_in && reg_addr_in == PTS_ADDR_OFF_DLY) begin
			next_off_dly = reg_wdata_in[5:0];
		end
		case (reg_addr_in)
			PTS_ADDR_RAMP:    next_rdata = {1'b0, ramp_rate_register};
			PTS_ADDR_OFF_DLY: next_rdata = {2'b00, turn_off_delay_ms};
			default:          next_rdata = 8'h00;
		endcase
	end

	// Register storage.
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			ramp_rate_register <= PTS_RAMP_RESET;
			turn_off_delay_ms  <= PTS_OFF_RESET;
			reg_rdata_out      <= 8'h00;
		end else begin
			ramp_rate_register <= next_ramp_rate;
			turn_off_delay_ms  <= next_off_dly;
			reg_rdata_out      <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Slew decode; rising and falling codes are decoded separately.

	assign fall_slew_enable  = ramp_rate_register[PTS_SLEW_BIT];
	assign rise_us           = pts_step_us(ramp_rate_register[PTS_RISE_LSB +: 3]);
	assign fall_us           = pts_step_us(ramp_rate_register[PTS_FALL_LSB +: 3]);
	assign need_us           = 18'(vref_out) * 18'(fall_us);
	assign tick.step_len_us  = (state == ST_RAMP_DOWN || state == ST_OFF_DLY) ? fall_us : rise_us;
	assign tick.step_restart = restart;

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer.

	// Next state, delay counters and reference.
	always_comb begin
		next_state  = state;
		next_vref   = vref_out;
		next_on_cnt = on_cnt;
		next_rem_us = rem_us;
		next_hold   = hold;
		restart     = 1'b0;
		case (state)
			ST_OFF: begin
				next_vref = 10'h000;
				next_hold = 1'b1;
				if (turn_on_cmd_in) begin
					next_on_cnt = turn_on_delay_ms_in;
					next_state  = ST_ON_DLY;
				end
			end
			ST_ON_DLY: begin
				if (on_cnt == 8'h00) begin
					next_state = ST_RAMP_UP;
					restart    = 1'b1;
				end else if (tick.ms_tick) begin
					next_on_cnt = on_cnt - 8'h01;
				end
			end
			ST_RAMP_UP: begin
				if (vref_out >= vout_target_in) begin
					next_state = ST_ON;
				end else if (tick.step_tick) begin
					next_vref = vref_out + 10'h001;
				end
				if (hold && vref_out > vout_sense_in) begin
					next_hold = 1'b0;
				end
			end
			ST_ON: begin
				next_hold = 1'b0;
			end
			ST_OFF_DLY: begin
				if (fall_slew_enable && need_us >= {2'b00, rem_us}) begin
					next_state = ST_RAMP_DOWN;
					restart    = 1'b1;
				end else if (rem_us == 16'h0000) begin
					next_state = ST_OFF;
					next_vref  = 10'h000;
				end else if (tick.us_tick) begin
					next_rem_us = rem_us - 16'h0001;
				end
			end
			ST_RAMP_DOWN: begin
				if (vref_out == 10'h000) begin
					next_state = ST_OFF;
				end else if (tick.step_tick) begin
					next_vref = vref_out - 10'h001;
				end
			end
			default: begin
				next_state = ST_OFF;
			end
		endcase
		// Turn-off takes over from any powering-up or on state.
		if (turn_off_cmd_in && (state == ST_ON_DLY || state == ST_RAMP_UP || state == ST_ON)) begin
			next_state  = ST_OFF_DLY;
			next_rem_us = 16'(turn_off_delay_ms) * 16'(PTS_US_PER_MS);
		end
		next_switch = !next_hold && (next_state == ST_RAMP_UP || next_state == ST_ON ||
			next_state == ST_OFF_DLY || next_state == ST_RAMP_DOWN);
		next_done = (next_state == ST_ON);
	end

	// Sequencer registers.
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			state             <= ST_OFF;
			vref_out          <= 10'h000;
			on_cnt            <= 8'h00;
			rem_us            <= 16'h0000;
			hold              <= 1'b1;
			switch_enable_out <= 1'b0;
			ramp_done_out     <= 1'b0;
		end else begin
			state             <= next_state;
			vref_out          <= next_vref;
			on_cnt            <= next_on_cnt;
			rem_us            <= next_rem_us;
			hold              <= next_hold;
			switch_enable_out <= next_switch;
			ramp_done_out     <= next_done;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (reset_in);

	property p_ramp_down_ends;
		state == ST_RAMP_DOWN && vref_out == 10'h000 |=> state == ST_OFF ##1 !switch_enable_out;
	endproperty
	a_ramp_down_ends: assert property (p_ramp_down_ends) else $error("ramp-down did not end in off");

	property p_pre_ramp;
		state == ST_OFF_DLY && fall_slew_enable && need_us >= {2'b00, rem_us} |=> state == ST_RAMP_DOWN;
	endproperty
	a_pre_ramp: assert property (p_pre_ramp) else $error("ramp-down not started after pre-ramp delay");

	property p_hard_off;
		state == ST_OFF_DLY && !fall_slew_enable && rem_us == 16'h0000 |=> !switch_enable_out && vref_out == 10'h000;
	endproperty
	a_hard_off: assert property (p_hard_off) else $error("switches not off at delay expiry");

	property p_off_dly_write;
		reg_wr_in && reg_addr_in == PTS_ADDR_OFF_DLY |=> turn_off_delay_ms == $past(reg_wdata_in[5:0]);
	endproperty
	a_off_dly_write: assert property (p_off_dly_write) else $error("turn-off delay not stored");

	property p_upper_zero;
		reg_addr_in == PTS_ADDR_OFF_DLY |=> reg_rdata_out[7:6] == 2'b00 && reg_rdata_out[5:0] == $past(turn_off_delay_ms);
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("turn-off delay read back wrong");

	property p_step_up;
		state == ST_RAMP_UP && tick.step_tick && vref_out < vout_target_in && !turn_off_cmd_in
			|=> vref_out == $past(vref_out) + 10'h001;
	endproperty
	a_step_up: assert property (p_step_up) else $error("reference did not rise by one step");

	property p_prebias_hold;
		state == ST_RAMP_UP && $rose(switch_enable_out) |-> $past(vref_out) > $past(vout_sense_in);
	endproperty
	a_prebias_hold: assert property (p_prebias_hold) else $error("switches active before ramp crossed output");

	property p_on_delay_end;
		state == ST_ON_DLY && on_cnt == 8'h00 && !turn_off_cmd_in |=> state == ST_RAMP_UP && vref_out == 10'h000;
	endproperty
	a_on_delay_end: assert property (p_on_delay_end) else $error("ramp did not start at turn-on delay end");

	property p_slew_bit;
		reg_wr_in && reg_addr_in == PTS_ADDR_RAMP |=> fall_slew_enable == $past(reg_wdata_in[3])
			&& fall_us == pts_step_us($past(reg_wdata_in[2:0]));
	endproperty
	a_slew_bit: assert property (p_slew_bit) else $error("falling slew settings not applied");

endmodule

`default_nettype wire

// ---- pts_mgr_model.sv ----
// Purpose: Power manager stand-in that supplies the shared master clock.
// Assumes: Only the clock leaves the manager; register traffic is driven by the bench.
// Notes:   Clock is sped up so one counted millisecond is 10000 system cycles.
`default_nettype none

module pts_mgr_model #(
	parameter int HALF_NS = 20
) (
	// Master clock pin.
	output var logic master_clk_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// Free-running master clock; every converter steps from the same edges.
	initial begin
		master_clk_out = 1'b0;
		forever #(HALF_NS) master_clk_out = ~master_clk_out;
	end
endmodule

`default_nettype wire

// ---- testbench.sv ----
// Purpose: Self-checking bench for the turn-on/turn-off sequencer.
// Assumes: Master clock of 40 ns, so 1 us is 10 cycles and 1 ms is 10000 cycles.
// Notes:   Time windows allow a few cycles for the master clock synchroniser.
`default_nettype none

module testbench;
	import pts_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic       sys_clk_in = 1'b0;
	logic       reset_in = 1'b1;
	logic       master_clk;
	logic [7:0] reg_addr_in = 8'h00;
	logic       reg_wr_in = 1'b0;
	logic [7:0] reg_wdata_in = 8'h00;
	logic [7:0] reg_rdata_out;
	logic       on_cmd = 1'b0;
	logic       off_cmd = 1'b0;
	logic [7:0] on_dly = 8'h01;
	logic [9:0] vref_out;
	logic       switch_enable_out;
	logic       ramp_done_out;
	int         error_cnt = 0;
	int         checks = 0;
	int         n1, n2, n3;

	////////////////////////////////////////////////////////////////
	// Clock, partner and design.
	always #2 sys_clk_in = ~sys_clk_in;

	pts_mgr_model pts_mgr_model_i (.master_clk_out(master_clk));

	pts_sequencer pts_sequencer_i (
		.sys_clk_in(sys_clk_in), .reset_in(reset_in), .master_clk_in(master_clk),
		.reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
		.reg_rdata_out(reg_rdata_out), .turn_on_cmd_in(on_cmd), .turn_off_cmd_in(off_cmd),
		.turn_on_delay_ms_in(on_dly), .vout_target_in(10'h014), .vout_sense_in(10'h005),
		.vref_out(vref_out), .switch_enable_out(switch_enable_out), .ramp_done_out(ramp_done_out)
	);

	////////////////////////////////////////////////////////////////
	// Tasks.
	// Compares a value and counts the outcome.
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Checks that a count lies inside a window.
	task automatic rng(input int n, input int lo, input int hi);
		chk(10'((n >= lo) && (n <= hi)), 10'h001);
	endtask

	// Writes one register with a one-cycle strobe.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
		@(posedge sys_clk_in);
	endtask

	// Reads one register; data appears one cycle after the address.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		@(posedge sys_clk_in);
		@(negedge sys_clk_in);
		chk({2'h0, reg_rdata_out}, {2'h0, exp});
	endtask

	// Pulses a command for one cycle.
	task automatic cmd(input logic on);
		@(posedge sys_clk_in);
		if (on) on_cmd <= 1'b1;
		else off_cmd <= 1'b1;
		@(posedge sys_clk_in);
		on_cmd <= 1'b0;
		off_cmd <= 1'b0;
	endtask

	// Counts cycles until an output reaches a value: 0 vref, 1 switch, 2 done.
	task automatic wait_on(input int sel, input logic [9:0] v, input int max, output int n);
		logic [9:0] s;
		n = 0;
		forever begin
			@(negedge sys_clk_in);
			s = (sel == 0) ? vref_out : (sel == 1) ? {9'h0, switch_enable_out} : {9'h0, ramp_done_out};
			if (s === v || n >= max) break;
			n++;
		end
		chk(s, v);
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Watchdog sized well above the roughly 35000 cycles of the tests.
	initial begin
		repeat (90000) @(posedge sys_clk_in);
		error_cnt++;
		$display("Error at %0t: timeout, got %h expected %h", $time, 1'b0, 1'b1);
		final_report();
	end

	////////////////////////////////////////////////////////////////
	// Test sequence.
	initial begin
		repeat (5) @(posedge sys_clk_in);
		reset_in <= 1'b0;
		rd(8'h03, 8'h1C);
		rd(8'h06, 8'h0B);
		rd(8'h00, 8'h00);
		wr(8'h06, 8'hFF);
		rd(8'h06, 8'h3F);
		wr(8'h03, 8'hFF);
		rd(8'h03, 8'h7F);
		// Rise 2.0 V/ms, slewed turn-off at 1.0 V/ms, 1 ms off delay long enough for 0.2 V.
		wr(8'h03, 8'h6D);
		wr(8'h06, 8'h01);
		rd(8'h03, 8'h6D);
		// Turn-on into a 50 mV pre-bias, ramping to 200 mV.
		cmd(1'b1);
		wait_on(0, 10'h001, 10400, n1);
		// The first millisecond tick lands about 10000 cycles after reset, so the ramp cannot start early.
		rng(n1, 9000, 10400);
		wait_on(0, 10'h005, 300, n1);
		chk({9'h0, switch_enable_out}, 10'h000);
		wait_on(0, 10'h007, 120, n1);
		chk({9'h0, switch_enable_out}, 10'h001);
		wait_on(0, 10'h008, 80, n1);
		rng(n1, 47, 52);
		wait_on(2, 10'h001, 800, n1);
		chk(vref_out, 10'h014);
		// Slewed turn-off: ramp ends with the 1 ms delay.
		cmd(1'b0);
		wait_on(0, 10'h013, 10500, n1);
		wait_on(0, 10'h012, 150, n2);
		rng(n2, 97, 102);
		wait_on(0, 10'h000, 2000, n3);
		rng(n1 + n2 + n3, 9700, 10300);
		wait_on(1, 10'h000, 3, n1);
		// Unslewed turn-off: switches drop at expiry with no ramp.
		// Rise at 0.5 V/ms with falling slew off: 20 us per step is 200 cycles.
		wr(8'h03, 8'h45);
		on_dly <= 8'h00;
		cmd(1'b1);
		wait_on(0, 10'h007, 1600, n1);
		wait_on(0, 10'h008, 250, n1);
		rng(n1, 197, 202);
		wait_on(2, 10'h001, 12000, n1);
		cmd(1'b0);
		wait_on(0, 10'h000, 10500, n1);
		rng(n1, 9700, 10300);
		wait_on(1, 10'h000, 2, n2);
		final_report();
	end
endmodule

`default_nettype wire
